// *** hdl/srb_map.svh ***
// Register offsets, bit positions, reset values and baud factors
// Assumes byte addresses on a 32-bit APB with one register per word
`ifndef SRB_MAP_SVH
`define SRB_MAP_SVH

`define SRB_OFF_RSC      8'h00
`define SRB_OFF_BRC      8'h04
`define SRB_OFF_DVL      8'h08
`define SRB_OFF_DVH      8'h0C
`define SRB_OFF_RXD      8'h10
`define SRB_OFF_MOD      8'h14

`define SRB_B_PORT_ENABLE       7
`define SRB_B_RX9        6
`define SRB_B_SINGLE_RECEIVE_ENABLE       5
`define SRB_B_CONTINUOUS_RECEIVE_ENABLE       4
`define SRB_B_ADDRESS_DETECT_ENABLE      3
`define SRB_B_FRAMING_ERROR_FLAG       2
`define SRB_B_OVERRUN_ERROR_FLAG       1
`define SRB_B_RECEIVED_NINTH_BIT       0

`define SRB_B_AUTOBAUD_ROLLOVER_FLAG     7
`define SRB_B_IDLE       6
`define SRB_B_RXPOL      5
`define SRB_B_TXPOL      4
`define SRB_B_WIDE       3
`define SRB_B_INFRARED_CODEC_ENABLE       2
`define SRB_B_WUE        1
`define SRB_B_AUTOBAUD_ENABLE      0

`define SRB_B_SYNC       0
`define SRB_B_HIGH_SPEED_SELECT       1
`define SRB_B_CLOCK_SOURCE_SELECT       2

`define SRB_RST_RSC      8'h00
`define SRB_RST_BRC      8'h40
`define SRB_RST_MOD      8'h00

`define SRB_FACT_SLOW    7'h40
`define SRB_FACT_FAST    7'h10
`define SRB_FACT_SYNC    7'h04
`define SRB_ABD_FALLS    3'h4

`endif

// *** hdl/srb_pkg.sv ***
// Types shared by the serial receive and baud control block
// Assumes nothing beyond a SystemVerilog compiler
package srb_pkg;

	typedef enum logic [1:0] {
		SRB_IDLE  = 2'b00,
		SRB_START = 2'b01,
		SRB_DATA  = 2'b10,
		SRB_STOP  = 2'b11
	} srb_state_t;

	typedef struct packed {
		logic        port_enable;
		logic        rx9;
		logic        single_receive_enable;
		logic        continuous_receive_enable;
		logic        address_detect_enable;
		logic        framing_error_flag;
		logic        overrun_error_flag;
		logic        received_ninth_bit;
		logic        autobaud_rollover_flag;
		logic        receive_polarity_select;
		logic        transmit_clock_polarity_select;
		logic        wide_divisor_enable;
		logic        infrared_codec_enable;
		logic        wakeup_enable;
		logic        autobaud_enable;
		logic        sync;
		logic        high_speed_select;
		logic        clock_source_select;
		logic [7:0]  div_lo;
		logic [7:0]  div_hi;
		logic [7:0]  rbuf;
		logic        full;
		logic [15:0] baud_generator;
		srb_state_t  st;
		logic [6:0]  t;
		logic [1:0]  smp;
		logic [3:0]  bitn;
		logic [8:0]  sh;
		logic        r1;
		logic        r2;
		logic        rx_prev;
		logic        c1;
		logic        c2;
		logic        c_prev;
		logic        wake_arm;
		logic [2:0]  abd_falls;
		logic [9:0]  abd_pre;
		logic [15:0] abd_cnt;
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		logic        rdy_evt;
		logic        wake_evt;
		logic        ck_out;
		logic        ck_oe;
		logic        tx_idle;
	} srb_regs_t;

endpackage

// *** hdl/srb_core.sv ***
// Receive control, status and baud generator of a serial port, APB slave
// Assumes pclk at 10 MHz, pins asynchronous to pclk, one APB master
//
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "srb_map.svh"
`default_nettype none

module srb_core
	import srb_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              rx_pin,
	input  wire logic              ck_pin_in,
	output logic                   ck_pin_out,
	output logic                   ck_pin_oe,
	output logic                   tx_idle_level,
	output logic                   rx_byte_event,
	output logic                   wake_event
);

	if (ADDR_W < 5) begin : g_chk
		$error("ADDR_W too small for the register map");
	end

	srb_regs_t   s;
	srb_regs_t   n;
	logic        ir;
	logic        rxd;
	logic        fall;
	logic        rise;
	logic        act;
	logic        cedge;
	logic [15:0] lim;
	logic        tick;
	logic [6:0]  fact;
	logic [6:0]  mid;
	logic        acc;
	logic        wr;
	logic        rd;
	logic        hit;
	logic [7:0]  addr;
	logic        en_a;
	logic        en_s;
	logic        sm;
	logic        smp;
	logic        vote;
	logic        done;
	logic        fe;
	logic        ninth;
	logic        accept;
	logic [3:0]  last;
	logic [15:0] abd_div;

	always_comb begin
		n = s;
		ir = 1'h0;
		rxd = 1'h0;
		fall = 1'h0;
		rise = 1'h0;
		act = 1'h0;
		cedge = 1'h0;
		lim = 16'h0000;
		tick = 1'h0;
		fact = `SRB_FACT_SLOW;
		mid = 7'h00;
		acc = 1'h0;
		wr = 1'h0;
		rd = 1'h0;
		hit = 1'h0;
		addr = 8'h00;
		en_a = 1'h0;
		en_s = 1'h0;
		sm = 1'h0;
		smp = 1'h0;
		vote = 1'h0;
		done = 1'h0;
		fe = 1'h0;
		ninth = 1'h0;
		accept = 1'h0;
		last = 4'h7;
		abd_div = 16'h0000;
		n.rdy_evt = 1'h0;
		n.wake_evt = 1'h0;

		// Pin synchronisers
		n.r1 = rx_pin;
		n.r2 = s.r1;
		n.c1 = ck_pin_in;
		n.c2 = s.c1;

		ir = s.infrared_codec_enable & ~s.sync;
		// Infrared decoder reads a high pulse as zero; polarity ignored
		rxd = ir ? ~s.r2 : (s.r2 ^ s.receive_polarity_select);
		n.rx_prev = rxd;
		fall = s.rx_prev & ~rxd;
		rise = ~s.rx_prev & rxd;
		act = s.c2 ^ s.transmit_clock_polarity_select;
		n.c_prev = act;
		cedge = s.c_prev & ~act;

		// Baud timer
		lim = s.wide_divisor_enable ? {s.div_hi, s.div_lo} : {8'h00, s.div_lo};
		tick = (s.baud_generator == lim);
		n.baud_generator = tick ? 16'h0000 : s.baud_generator + 16'h0001;
		if (s.sync || (s.wide_divisor_enable && s.high_speed_select)) begin
			fact = `SRB_FACT_SYNC;
		end else if (s.wide_divisor_enable || s.high_speed_select) begin
			fact = `SRB_FACT_FAST;
		end else begin
			fact = `SRB_FACT_SLOW;
		end
		mid = fact >> 1;

		// APB: one wait state, then pready
		addr = 8'(paddr);
		hit = (paddr[1:0] == 2'h0) && (paddr <= ADDR_W'(`SRB_OFF_MOD));
		acc = psel & penable & ~s.pready;
		n.pready = acc;
		n.pslverr = acc & ~hit;
		wr = psel & penable & s.pready & pwrite & hit;
		rd = psel & penable & s.pready & ~pwrite & hit;
		if (acc) begin
			n.prdata = 32'h0000_0000;
			unique case (addr)
				`SRB_OFF_RSC: begin
					n.prdata[`SRB_B_PORT_ENABLE] = s.port_enable;
					n.prdata[`SRB_B_RX9] = s.rx9;
					n.prdata[`SRB_B_SINGLE_RECEIVE_ENABLE] = s.single_receive_enable;
					n.prdata[`SRB_B_CONTINUOUS_RECEIVE_ENABLE] = s.continuous_receive_enable;
					n.prdata[`SRB_B_ADDRESS_DETECT_ENABLE] = s.address_detect_enable;
					n.prdata[`SRB_B_FRAMING_ERROR_FLAG] = s.framing_error_flag;
					n.prdata[`SRB_B_OVERRUN_ERROR_FLAG] = s.overrun_error_flag;
					n.prdata[`SRB_B_RECEIVED_NINTH_BIT] = s.received_ninth_bit;
				end
				`SRB_OFF_BRC: begin
					n.prdata[`SRB_B_AUTOBAUD_ROLLOVER_FLAG] = s.autobaud_rollover_flag;
					n.prdata[`SRB_B_IDLE] = (s.st == SRB_IDLE);
					n.prdata[`SRB_B_RXPOL] = s.receive_polarity_select;
					n.prdata[`SRB_B_TXPOL] = s.transmit_clock_polarity_select;
					n.prdata[`SRB_B_WIDE] = s.wide_divisor_enable;
					n.prdata[`SRB_B_INFRARED_CODEC_ENABLE] = s.infrared_codec_enable;
					n.prdata[`SRB_B_WUE] = s.wakeup_enable;
					n.prdata[`SRB_B_AUTOBAUD_ENABLE] = s.autobaud_enable;
				end
				`SRB_OFF_DVL: n.prdata[7:0] = s.div_lo;
				`SRB_OFF_DVH: n.prdata[7:0] = s.div_hi;
				`SRB_OFF_RXD: n.prdata[7:0] = s.rbuf;
				`SRB_OFF_MOD: begin
					n.prdata[`SRB_B_SYNC] = s.sync;
					n.prdata[`SRB_B_HIGH_SPEED_SELECT] = s.high_speed_select;
					n.prdata[`SRB_B_CLOCK_SOURCE_SELECT] = s.clock_source_select;
				end
				default: n.prdata = 32'h0000_0000;
			endcase
		end
		if (wr) begin
			unique case (addr)
				`SRB_OFF_RSC: begin
					n.port_enable = pwdata[`SRB_B_PORT_ENABLE];
					n.rx9 = pwdata[`SRB_B_RX9];
					n.single_receive_enable = pwdata[`SRB_B_SINGLE_RECEIVE_ENABLE];
					n.continuous_receive_enable = pwdata[`SRB_B_CONTINUOUS_RECEIVE_ENABLE];
					n.address_detect_enable = pwdata[`SRB_B_ADDRESS_DETECT_ENABLE];
				end
				`SRB_OFF_BRC: begin
					n.autobaud_rollover_flag = s.autobaud_rollover_flag & pwdata[`SRB_B_AUTOBAUD_ROLLOVER_FLAG];
					n.receive_polarity_select = pwdata[`SRB_B_RXPOL];
					n.transmit_clock_polarity_select = pwdata[`SRB_B_TXPOL];
					n.wide_divisor_enable = pwdata[`SRB_B_WIDE];
					// Width change may leave the timer past the new limit
					if (pwdata[`SRB_B_WIDE] != s.wide_divisor_enable) begin
						n.baud_generator = 16'h0000;
					end
					n.infrared_codec_enable = pwdata[`SRB_B_INFRARED_CODEC_ENABLE];
					n.wakeup_enable = pwdata[`SRB_B_WUE];
					n.autobaud_enable = pwdata[`SRB_B_AUTOBAUD_ENABLE];
				end
				`SRB_OFF_DVL: begin
					n.div_lo = pwdata[7:0];
					n.baud_generator = 16'h0000;
				end
				`SRB_OFF_DVH: begin
					n.div_hi = pwdata[7:0];
					n.baud_generator = 16'h0000;
				end
				`SRB_OFF_MOD: begin
					n.sync = pwdata[`SRB_B_SYNC];
					n.high_speed_select = pwdata[`SRB_B_HIGH_SPEED_SELECT];
					n.clock_source_select = pwdata[`SRB_B_CLOCK_SOURCE_SELECT];
				end
				default: n.port_enable = s.port_enable;
			endcase
		end
		if (rd && addr == `SRB_OFF_RXD) begin
			n.full = 1'h0;
		end
		if (!n.continuous_receive_enable) begin
			n.overrun_error_flag = 1'h0;
		end
		if (!n.wakeup_enable) begin
			n.wake_arm = 1'h0;
		end

		// Receiver
		sm = s.sync & s.clock_source_select;
		en_a = ~s.sync & s.continuous_receive_enable & ~s.autobaud_enable & ~s.wakeup_enable & ~s.overrun_error_flag;
		en_s = s.sync & ~s.overrun_error_flag & (s.continuous_receive_enable | (sm & s.single_receive_enable));
		last = s.rx9 ? 4'h8 : 4'h7;
		if (s.st == SRB_IDLE) begin
			n.t = 7'h00;
			n.bitn = 4'h0;
			if (en_s) begin
				n.st = SRB_DATA;
			end else if (en_a && fall) begin
				n.st = SRB_START;
			end
		end else if (s.sync) begin
			if (!en_s) begin
				n.st = SRB_IDLE;
			end else begin
				if (sm && tick) begin
					n.t = (s.t >= fact - 7'h01) ? 7'h00 : s.t + 7'h01;
					smp = (s.t == 7'h02);
				end
				if (!s.clock_source_select && cedge) begin
					smp = 1'h1;
				end
				if (smp) begin
					n.sh = {rxd, s.sh[8:1]};
					n.bitn = s.bitn + 4'h1;
					if (s.bitn == last) begin
						n.bitn = 4'h0;
						done = 1'h1;
					end
				end
			end
		end else if (!en_a && !s.overrun_error_flag) begin
			n.st = SRB_IDLE;
		end else if (tick) begin
			n.t = (s.t >= fact - 7'h01) ? 7'h00 : s.t + 7'h01;
			if (s.t == mid - 7'h01 || s.t == mid) begin
				n.smp = {s.smp[0], rxd};
			end
			if (s.t == mid + 7'h01) begin
				vote = (s.smp[1] & s.smp[0]) | (rxd & (s.smp[1] | s.smp[0]));
				unique case (s.st)
					SRB_START: n.st = vote ? SRB_IDLE : SRB_DATA;
					SRB_DATA: begin
						n.sh = {vote, s.sh[8:1]};
						n.bitn = s.bitn + 4'h1;
						if (s.bitn == last) begin
							n.st = SRB_STOP;
						end
					end
					SRB_STOP: begin
						done = 1'h1;
						fe = ~vote;
						n.st = SRB_IDLE;
					end
					default: n.st = SRB_IDLE;
				endcase
			end
		end
		if (done) begin
			ninth = s.rx9 & n.sh[8];
			accept = ~(~s.sync & s.rx9 & s.address_detect_enable & ~ninth);
			if (accept) begin
				if (n.full) begin
					n.overrun_error_flag = 1'h1;
				end else begin
					n.rbuf = s.rx9 ? n.sh[7:0] : n.sh[8:1];
					n.received_ninth_bit = ninth;
					n.framing_error_flag = fe;
					n.full = 1'h1;
					n.rdy_evt = 1'h1;
				end
			end
			if (sm && !s.continuous_receive_enable) begin
				n.single_receive_enable = 1'h0;
			end
			if (s.sync) begin
				n.st = s.continuous_receive_enable ? SRB_DATA : SRB_IDLE;
			end
		end

		// Wake-up monitor
		if (!s.sync && s.wakeup_enable) begin
			if (fall) begin
				n.wake_evt = 1'h1;
				n.wake_arm = 1'h1;
			end else if (s.wake_arm && rise) begin
				n.wakeup_enable = 1'h0;
				n.wake_arm = 1'h0;
			end
		end

		// Auto-baud: time four bit pairs from the first to fifth fall
		if (!s.sync && s.autobaud_enable) begin
			if (fall) begin
				n.abd_falls = s.abd_falls + 3'h1;
				if (s.abd_falls == `SRB_ABD_FALLS) begin
					abd_div = (s.abd_cnt == 16'h0000) ? 16'h0000 : s.abd_cnt - 16'h0001;
					n.div_lo = abd_div[7:0];
					n.div_hi = abd_div[15:8];
					n.baud_generator = 16'h0000;
					n.autobaud_enable = 1'h0;
					n.abd_falls = 3'h0;
				end
			end
			if (s.abd_falls != 3'h0) begin
				n.abd_pre = s.abd_pre + 10'h001;
				if (s.abd_pre == {fact, 3'h0} - 10'h001) begin
					n.abd_pre = 10'h000;
					n.abd_cnt = s.abd_cnt + 16'h0001;
					if (s.abd_cnt == 16'hFFFF) begin
						n.autobaud_rollover_flag = 1'h1;
						n.autobaud_enable = 1'h0;
						n.abd_falls = 3'h0;
					end
				end
			end
		end else begin
			n.abd_falls = 3'h0;
			n.abd_pre = 10'h000;
			n.abd_cnt = 16'h0000;
		end

		// Port disabled: receiver and its flags held in reset
		if (!s.port_enable) begin
			n.st = SRB_IDLE;
			n.t = 7'h00;
			n.bitn = 4'h0;
			n.framing_error_flag = 1'h0;
			n.overrun_error_flag = 1'h0;
			n.full = 1'h0;
			n.wake_arm = 1'h0;
			n.abd_falls = 3'h0;
			n.rdy_evt = 1'h0;
			n.wake_evt = 1'h0;
		end

		n.ck_oe = n.port_enable & n.sync & n.clock_source_select;
		n.ck_out = n.transmit_clock_polarity_select ^ (n.st == SRB_DATA && n.sync && n.clock_source_select && n.t < 7'h02);
		n.tx_idle = (n.infrared_codec_enable & ~n.sync) ? n.transmit_clock_polarity_select : ~n.transmit_clock_polarity_select;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
			s.receive_polarity_select <= 1'h0;
			s.tx_idle <= 1'h1;
			s.r1 <= 1'h1;
			s.r2 <= 1'h1;
			s.rx_prev <= 1'h1;
		end else begin
			s <= n;
		end
	end

	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign ck_pin_out = s.ck_out;
	assign ck_pin_oe = s.ck_oe;
	assign tx_idle_level = s.tx_idle;
	assign rx_byte_event = s.rdy_evt;
	assign wake_event = s.wake_evt;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_port_off_idle: assert property (!s.port_enable |=> s.st == SRB_IDLE && !s.full)
		else $error("receiver active while port disabled");
	a_single_clear: assert property (done && s.sync && s.clock_source_select && !s.continuous_receive_enable |=> !s.single_receive_enable)
		else $error("single receive not cleared");
	a_addr_filter: assert property (done && !s.sync && s.rx9 && s.address_detect_enable && !n.sh[8] |=> !s.rdy_evt)
		else $error("address byte filter failed");
	a_overrun_error_flag_hold: assert property (s.overrun_error_flag && s.continuous_receive_enable && !wr |=> s.overrun_error_flag)
		else $error("overrun flag lost");
	a_overrun_error_flag_clear: assert property (s.port_enable && !s.continuous_receive_enable |=> !s.overrun_error_flag)
		else $error("overrun flag kept");
	a_autobaud_rollover_flag_sticky: assert property (s.autobaud_rollover_flag && !wr |=> s.autobaud_rollover_flag)
		else $error("rollover flag lost");
	a_div_restart: assert property (wr && (addr == `SRB_OFF_DVL) |=> s.baud_generator == 16'h0000)
		else $error("baud timer not restarted");
	a_narrow_div: assert property (!s.wide_divisor_enable && !wr |-> s.baud_generator <= {8'h00, s.div_lo})
		else $error("baud timer beyond low byte");
	a_clock_idle: assert property (s.st == SRB_IDLE && s.sync && s.clock_source_select |-> s.ck_out == s.transmit_clock_polarity_select)
		else $error("clock pin not idle");
	a_wake_clear: assert property (!s.sync && s.wakeup_enable && s.wake_arm && rise |=> !s.wakeup_enable)
		else $error("wake-up enable not cleared");
	a_apb_wait: assert property (psel && penable && !s.pready |=> s.pready ##1 !s.pready)
		else $error("pready timing wrong");

	c_byte_loaded: cover property (s.rdy_evt && !s.sync);
	c_frame_error: cover property (s.rdy_evt && s.framing_error_flag);
	c_autobaud_done: cover property (s.autobaud_enable ##1 !s.autobaud_enable && !s.autobaud_rollover_flag);
	c_sync_byte: cover property (s.rdy_evt && s.sync);

endmodule

`default_nettype wire

// *** sim/srb_peer.sv ***
// Remote serial peer: asynchronous frames on the receive line, slave clock and data
// Assumes the bench calls its tasks and gives the bit time in ns
`timescale 1ns/1ps
`default_nettype none

module srb_peer (
	output logic rx_line,
	output logic ck_line
);
	initial begin
		rx_line = 1'b1;
		ck_line = 1'b0;
	end

	// Line idles at the level the polarity gives; inverted idle is low
	task automatic set_idle(input logic inv);
		rx_line <= ~inv;
	endtask

	// Idle gap, start bit, data LSB first, then the stop bit
	task automatic send(input logic [8:0] d, input int nbits, input logic stop,
		input logic inv, input int bit_ns);
		rx_line <= ~inv;
		#(2 * bit_ns);
		rx_line <= inv;
		#(bit_ns);
		for (int i = 0; i < nbits; i++) begin
			rx_line <= d[i] ^ inv;
			#(bit_ns);
		end
		rx_line <= stop ^ inv;
		#(bit_ns);
		rx_line <= ~inv;
	endtask

	// Slave clock, idle low: data changes as the clock rises, taken as it falls
	task automatic clock_in(input logic [7:0] d, input int half_ns);
		for (int i = 0; i < 8; i++) begin
			rx_line <= d[i];
			ck_line <= 1'b1;
			#(half_ns);
			ck_line <= 1'b0;
			#(half_ns);
		end
		rx_line <= 1'b1;
	endtask
endmodule

`default_nettype wire

// *** sim/tb.sv ***
// Self-checking bench for the serial receive and baud control block
// Assumes srb_core, srb_peer and the register map header
`timescale 1ns/1ps
`include "srb_map.svh"
`default_nettype none

module tb;
	localparam int BIT_NS = 1600;
	localparam logic [31:0] ALL = 32'hFF;
	localparam logic [31:0] NB = 32'hFE;
	logic        pclk, presetn, psel, penable, pwrite, e;
	logic [7:0]  paddr, d;
	logic [31:0] pwdata, prdata, q, base;
	logic [31:0] ev_cnt = '0;
	logic [31:0] wk_cnt = '0;
	logic        pready, pslverr, rx_pin, ck_pin_in, ck_pin_out, ck_pin_oe;
	logic        tx_idle_level, rx_byte_event, wake_event;
	int          bad_count, checks_done;

	srb_core #(.ADDR_W(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin),
		.ck_pin_in(ck_pin_in), .ck_pin_out(ck_pin_out), .ck_pin_oe(ck_pin_oe),
		.tx_idle_level(tx_idle_level), .rx_byte_event(rx_byte_event),
		.wake_event(wake_event));
	srb_peer peer (.rx_line(rx_pin), .ck_line(ck_pin_in));

	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		if (rx_byte_event === 1'b1)
			ev_cnt <= ev_cnt + 1;
	end

	always @(posedge pclk) begin
		if (wake_event === 1'b1)
			wk_cnt <= wk_cnt + 1;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dat);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= dat;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50)
			chk(32'h0, 32'h1, "bus answer missing");
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] dat);
		apb(1'b1, a, dat);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mk,
		input string m);
		apb(1'b0, a, 32'h0);
		chk(q & mk, exp, m);
	endtask

	// Waits, bounded, for exactly one loaded byte since base was taken
	task automatic wait_byte(input string m);
		int n;
		n = 0;
		while (ev_cnt == base && n < 300) begin
			@(posedge pclk);
			n++;
		end
		chk(ev_cnt, base + 1, m);
	endtask

	// Sends one frame and waits for its byte
	task automatic rx(input logic [8:0] v, input int nb, input logic stop, input logic inv);
		base = ev_cnt;
		peer.send(v, nb, stop, inv, BIT_NS);
		wait_byte("byte event");
	endtask

	// Expected status register from control bits and the two error flags
	function automatic logic [31:0] rsc_val(input logic [7:0] ctl, input logic fe,
		input logic oe);
		logic [31:0] v;
		v = {24'h0, ctl};
		v[`SRB_B_FRAMING_ERROR_FLAG] = fe;
		v[`SRB_B_OVERRUN_ERROR_FLAG] = oe;
		return v;
	endfunction

	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		#(40000 * 100);
		bad_count++;
		$display("wrong value at %0t: watchdog expired", $time);
		end_of_test();
	end

	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		presetn = 1'b0;
		bad_count = 0;
		checks_done = 0;
		void'($urandom(32'h9c774c30));
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		chk(tx_idle_level, 32'h1, "reset idle level");
		rd(`SRB_OFF_RSC, 32'h00, NB, "rsc reset");
		rd(`SRB_OFF_BRC, 32'h40, ALL, "brc reset");
		rd(`SRB_OFF_MOD, 32'h00, ALL, "mode reset");
		rd(8'h40, 32'h00, ALL, "unmapped read");
		chk(e, 32'h1, "unmapped error");
		$display("test reset done");
		// Factor four with divisor three gives sixteen clocks per bit
		wr(`SRB_OFF_MOD, 32'h02);
		wr(`SRB_OFF_BRC, 32'h08);
		wr(`SRB_OFF_DVL, 32'h03);
		wr(`SRB_OFF_DVH, 32'h00);
		wr(`SRB_OFF_RSC, 32'h90);
		for (int i = 0; i < 4; i++) begin
			d = 8'($urandom);
			rx({1'b0, d}, 8, 1'b1, 1'b0);
			rd(`SRB_OFF_RXD, {24'h0, d}, ALL, "random byte");
		end
		rd(`SRB_OFF_BRC, 32'h48, ALL, "idle after bytes");
		$display("test async bytes done");
		// Receiver off while line and polarity change, so no false start
		wr(`SRB_OFF_RSC, 32'h80);
		peer.set_idle(1'b1);
		wr(`SRB_OFF_BRC, 32'h28);
		wr(`SRB_OFF_RSC, 32'h90);
		rx(9'h03C, 8, 1'b1, 1'b1);
		rd(`SRB_OFF_RXD, 32'h3C, ALL, "inverted byte");
		wr(`SRB_OFF_RSC, 32'h80);
		peer.set_idle(1'b0);
		wr(`SRB_OFF_BRC, 32'h08);
		$display("test polarity done");
		wr(`SRB_OFF_RSC, 32'hD8);
		base = ev_cnt;
		peer.send(9'h033, 9, 1'b1, 1'b0, BIT_NS);
		repeat (40) @(posedge pclk);
		chk(ev_cnt, base, "data byte dropped");
		rx(9'h1A5, 9, 1'b1, 1'b0);
		rd(`SRB_OFF_RSC, 32'hD9, ALL, "ninth bit shown");
		rd(`SRB_OFF_RXD, 32'hA5, ALL, "address byte");
		$display("test address detect done");
		wr(`SRB_OFF_RSC, 32'h90);
		rx(9'h05A, 8, 1'b0, 1'b0);
		rd(`SRB_OFF_RSC, rsc_val(8'h90, 1'b1, 1'b0), NB, "framing set");
		rd(`SRB_OFF_RXD, 32'h5A, ALL, "framed byte");
		rx(9'h0C3, 8, 1'b1, 1'b0);
		rd(`SRB_OFF_RSC, 32'h90, NB, "framing cleared");
		rd(`SRB_OFF_RXD, 32'hC3, ALL, "good byte");
		$display("test framing done");
		rx(9'h011, 8, 1'b1, 1'b0);
		peer.send(9'h022, 8, 1'b1, 1'b0, BIT_NS);
		repeat (40) @(posedge pclk);
		rd(`SRB_OFF_RSC, rsc_val(8'h90, 1'b0, 1'b1), NB, "overrun set");
		rd(`SRB_OFF_RXD, 32'h11, ALL, "first byte kept");
		wr(`SRB_OFF_RSC, 32'h80);
		rd(`SRB_OFF_RSC, 32'h80, NB, "overrun cleared");
		$display("test overrun done");
		wr(`SRB_OFF_BRC, 32'h0A);
		peer.send(9'h000, 8, 1'b1, 1'b0, BIT_NS);
		repeat (20) @(posedge pclk);
		chk(wk_cnt, 32'h1, "wake event");
		rd(`SRB_OFF_BRC, 32'h08, 32'h0A, "wake cleared");
		$display("test wake done");
		wr(`SRB_OFF_BRC, 32'h18);
		repeat (2) @(posedge pclk);
		chk(tx_idle_level, 32'h0, "tx idle low");
		wr(`SRB_OFF_BRC, 32'h1C);
		repeat (2) @(posedge pclk);
		chk(tx_idle_level, 32'h1, "infrared idle high");
		wr(`SRB_OFF_MOD, 32'h05);
		wr(`SRB_OFF_DVL, 32'h03);
		wr(`SRB_OFF_BRC, 32'h10);
		repeat (2) @(posedge pclk);
		chk(ck_pin_oe, 32'h1, "master drives clock");
		chk(ck_pin_out, 32'h1, "clock idles high");
		wr(`SRB_OFF_BRC, 32'h00);
		repeat (2) @(posedge pclk);
		chk(ck_pin_out, 32'h0, "clock idles low");
		wr(`SRB_OFF_RSC, 32'h00);
		repeat (2) @(posedge pclk);
		chk(ck_pin_oe, 32'h0, "disabled port");
		$display("test pins done");
		wr(`SRB_OFF_MOD, 32'h02);
		wr(`SRB_OFF_RSC, 32'h90);
		wr(`SRB_OFF_BRC, 32'h09);
		// Sync character at a slightly slower bit time keeps the division clear of a boundary
		peer.send(9'h055, 8, 1'b1, 1'b0, 1650);
		repeat (20) @(posedge pclk);
		rd(`SRB_OFF_BRC, 32'h08, 32'h09, "autobaud cleared");
		rd(`SRB_OFF_DVL, 32'h03, ALL, "measured divisor");
		$display("test autobaud done");
		wr(`SRB_OFF_MOD, 32'h01);
		d = 8'($urandom);
		base = ev_cnt;
		peer.clock_in(d, 400);
		wait_byte("slave byte event");
		rd(`SRB_OFF_RXD, {24'h0, d}, ALL, "slave byte");
		wr(`SRB_OFF_RSC, 32'h80);
		wr(`SRB_OFF_MOD, 32'h05);
		base = ev_cnt;
		wr(`SRB_OFF_RSC, 32'hA0);
		wait_byte("single event");
		rd(`SRB_OFF_RSC, 32'h80, NB, "single cleared");
		rd(`SRB_OFF_RXD, 32'hFF, ALL, "master byte");
		$display("test sync done");
		end_of_test();
	end
endmodule

`default_nettype wire
